// ==== verilog/pot_pkg.sv ====
// Purpose: shared constants for the quad potentiometer command core
// Assumes: 250 MHz core clock, AHB-Lite register window of four words
// Notes: timing counts derive from printed times and the clock rate
package pot_pkg;
  // clock rate and derived timing counts
  localparam int CLK_MHZ = 250;
  localparam int STORE_MS = 15; // nonvolatile store lock time
  localparam int STORE_CYCLES = STORE_MS * CLK_MHZ * 1000;
  localparam int RESET_US = 30; // software reset reload time
  localparam int RESET_CYCLES = RESET_US * CLK_MHZ;
  localparam int TIMER_W = 22; // holds the store count
  // channel and byte geometry
  localparam int NUM_CH = 4;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BIT_MSB = 4'h7; // first data bit index, the msb
  localparam logic [3:0] BIT_ACK = 4'h8; // rises seen before ack slot
  localparam logic [3:0] BIT_END = 4'h9; // ack slot clocked
  // command word fields in the two received bytes
  localparam int CODE_LSB = 4; // control field in first byte
  localparam int ALL_BIT = 3; // all-channel select in first byte
  localparam int NONE_BIT = 2; // no-channel select in first byte
  localparam int DIR_BIT = 0; // read/write bit of address byte
  localparam int D0_BIT = 0;
  localparam int D1_BIT = 1;
  // command codes
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] CMD_WR_PRE = 4'h2;
  localparam logic [3:0] CMD_READBACK = 4'h3;
  localparam logic [3:0] CMD_TRANSFER = 4'h6;
  localparam logic [3:0] CMD_NV_COPY = 4'h7;
  localparam logic [3:0] CMD_NV_WRITE = 4'h8;
  localparam logic [3:0] CMD_SOFT_RESET = 4'hB;
  localparam logic [3:0] CMD_SHUTDOWN = 4'hC;
  // readback source selects
  localparam logic [1:0] RB_NVM = 2'h1;
  localparam logic [1:0] RB_WIPER = 2'h3;
  // address strap codes and slave addresses
  localparam logic [1:0] ASEL_GND = 2'h0;
  localparam logic [1:0] ASEL_FLOAT = 2'h1;
  localparam logic [1:0] ASEL_VDD = 2'h2;
  localparam logic [6:0] SADDR_VDD = 7'h28;
  localparam logic [6:0] SADDR_FLOAT = 7'h2A;
  localparam logic [6:0] SADDR_GND = 7'h2B;
  // factory nonvolatile content, midscale
  localparam logic [7:0] NVM_DEFAULT = 8'h80;
  // register window byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WIPER = 8'h08;
  localparam logic [7:0] REG_NVM = 8'h0C;
  localparam logic CTRL_RESET = 1'h1; // slave enabled
  localparam int HTRANS_ACT_BIT = 1; // NONSEQ or SEQ
endpackage

// ==== verilog/quad_pot_i2c_command_core.sv ====
// Purpose: serial slave and command core of a quad digital potentiometer
// Assumes: scl, sda and strap come from outside and are synchronised
// Notes: sda is open drain, sda_oe high pulls the line low
//
// Notes on behaviour
// - wiper tap follows wiper setting register directly
// - nonvolatile store locks and refuses acknowledges
// - power-up loads wipers from nonvolatile memory
// - 16-bit word: control, channel, data, MSB first
// - 256-position variant ignores data bit zero
// - works at standard and fast bus rates
// - only 7-bit addressing, no general call
// - address match acknowledged in ninth pulse
// - last address bit high means master reads
// - nine pulses per byte, receiver acknowledges
// - sda changes only while scl is low
// - slave address chosen by address strap pin
// - code 0001 writes wiper setting register
// - code 0010 writes preload register only
// - code 0011 selects readback source
// - code 0111 copies wiper to/from nonvolatile
// - separate command writes nonvolatile directly
// - channel field: all channels or one of four
// - each channel holds a preload register
// - transfer command copies preload into wiper
// - wiper load also overwrites preload register
// - code 1011 reloads wipers from nonvolatile memory
// - code 1100 enters or leaves shutdown
`timescale 1ns/1ns
module quad_pot_i2c_command_core
  import pot_pkg::*;
#(
  parameter int POSITIONS = 256,
  parameter int STORE_CNT = STORE_CYCLES,
  parameter int RESET_CNT = RESET_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [1:0] addr_sel,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic sda_o,
  output logic sda_oe,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] wiper_tap,
  output logic [3:0] shutdown
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_WAIT}
    i2c_state_t;
  // bit zero dropped on the 256-position variant
  localparam logic [7:0] LSB_MASK = (POSITIONS == 256) ? 8'hFE : 8'hFF;
  localparam logic [TIMER_W-1:0] STORE_LOAD = TIMER_W'(STORE_CNT);
  localparam logic [TIMER_W-1:0] RESET_LOAD = TIMER_W'(RESET_CNT);
  localparam logic [TIMER_W-1:0] ONE = TIMER_W'(1);
  logic [2:0] scl_sync; // bus clock synchroniser and delay
  logic [2:0] sda_sync; // bus data synchroniser and delay
  logic [1:0] asel_m; // strap first stage
  logic [1:0] asel_s; // strap second stage
  logic [6:0] own_addr_reg; // slave address from the strap
  logic scl_s, scl_d, sda_s, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  i2c_state_t state_reg;
  logic [3:0] bit_cnt_reg; // rising edges in current byte
  logic [7:0] shift_reg; // received bits
  logic byte_idx_reg; // 0 control byte, 1 data byte
  logic [7:0] cmd_hi_reg; // control and channel fields
  logic [7:0] cmd_data_reg; // data field
  logic cmd_go_reg; // one-cycle command strobe
  logic [7:0] wiper_reg [NUM_CH];
  logic [7:0] preload_reg [NUM_CH];
  logic [7:0] nvm_reg [NUM_CH];
  logic [1:0] rb_ch_reg; // readback channel
  logic [1:0] rb_src_reg; // readback source
  logic [7:0] rb_byte; // byte returned to master
  logic [TIMER_W-1:0] store_cnt_reg; // store lock timer
  logic [TIMER_W-1:0] rst_cnt_reg; // reload timer
  logic locked; // refuse to acknowledge
  logic load_now; // reload wipers this cycle
  logic ctrl_en_reg; // software enable of the serial slave
  logic [3:0] code;
  logic all_ch;
  logic [3:0] sel;
  logic [7:0] data_m;
  logic ahb_wr_reg;
  logic [7:0] ahb_addr_reg;
  logic [31:0] wiper_flat, nvm_flat;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers, first stage read only by the second
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  // bus event detection on synchronised copies
  assign scl_s = scl_sync[1];
  assign scl_d = scl_sync[2];
  assign sda_s = sda_sync[1];
  assign sda_d = sda_sync[2];
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // strap synchroniser and address lookup
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      asel_m <= ASEL_GND;
      asel_s <= ASEL_GND;
      own_addr_reg <= SADDR_GND;
    end
    else
    begin
      asel_m <= addr_sel;
      asel_s <= asel_m;
      // unknown strap code falls back to the grounded address
      unique case (asel_s)
        ASEL_VDD: own_addr_reg <= SADDR_VDD;
        ASEL_FLOAT: own_addr_reg <= SADDR_FLOAT;
        default: own_addr_reg <= SADDR_GND;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial slave: bits sampled on scl rise, sda driven after scl fall
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 1'b0;
      cmd_hi_reg <= 8'h00;
      cmd_data_reg <= 8'h00;
      cmd_go_reg <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      cmd_go_reg <= 1'b0;
      if (bus_start)
      begin
        // start or repeated start opens a new address byte
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        byte_idx_reg <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise && state_reg != ST_IDLE && state_reg != ST_WAIT)
      begin
        // shift in data bits msb first, count the ack slot too
        if (bit_cnt_reg < BIT_ACK)
          shift_reg <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        // master nack on a read ends our driving
        if (state_reg == ST_READ && bit_cnt_reg == BIT_ACK && sda_s)
          state_reg <= ST_WAIT;
      end
      else if (scl_fall && state_reg != ST_IDLE && state_reg != ST_WAIT)
      begin
        if (bit_cnt_reg == BIT_ACK)
        begin
          // eighth bit done: decide on the acknowledge
          unique case (state_reg)
            ST_ADDR:
            begin
              // fixed 7-bit compare never matches general call
              if (shift_reg[7:DIR_BIT+1] == own_addr_reg && !locked
                  && ctrl_en_reg)
              begin
                sda_oe <= 1'b1;
                state_reg <= shift_reg[DIR_BIT] ? ST_READ : ST_WRITE;
              end
              else
                state_reg <= ST_WAIT;
            end
            ST_WRITE:
            begin
              if (locked)
                state_reg <= ST_WAIT;
              else
              begin
                sda_oe <= 1'b1;
                byte_idx_reg <= ~byte_idx_reg;
                if (!byte_idx_reg)
                  cmd_hi_reg <= shift_reg;
                else
                begin
                  cmd_data_reg <= shift_reg;
                  cmd_go_reg <= 1'b1;
                end
              end
            end
            default: sda_oe <= 1'b0; // read: release for master ack
          endcase
        end
        else if (bit_cnt_reg == BIT_END)
        begin
          // ack slot over: release, or drive first bit of a read byte
          bit_cnt_reg <= 4'h0;
          sda_oe <= (state_reg == ST_READ) ? ~rb_byte[BIT_MSB[2:0]] : 1'b0;
        end
        else if (state_reg == ST_READ)
          sda_oe <= ~rb_byte[3'(BIT_MSB - bit_cnt_reg)];
      end
    end
  end

  // open drain pin only ever pulls low
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sda_o <= 1'b0;
    else
      sda_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode
  assign code = cmd_hi_reg[CODE_LSB +: 4];
  assign all_ch = cmd_hi_reg[ALL_BIT];
  assign sel = all_ch ? 4'hF : cmd_hi_reg[NONE_BIT] ? 4'h0
             : 4'(4'h1 << cmd_hi_reg[1:0]);
  assign data_m = cmd_data_reg & LSB_MASK;
  assign locked = (store_cnt_reg != '0) || (rst_cnt_reg != '0);
  assign load_now = (rst_cnt_reg == ONE);

  // per-channel wiper, preload, nonvolatile and shutdown state
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        wiper_reg[i] <= NVM_DEFAULT;
        preload_reg[i] <= NVM_DEFAULT;
      end
      else if (load_now)
      begin
        wiper_reg[i] <= nvm_reg[i];
        preload_reg[i] <= nvm_reg[i];
      end
      else if (cmd_go_reg && sel[i])
      begin
        if (code == CMD_WR_WIPER)
        begin
          wiper_reg[i] <= data_m;
          preload_reg[i] <= data_m;
        end
        else if (code == CMD_WR_PRE)
          preload_reg[i] <= data_m;
        else if (code == CMD_TRANSFER)
          wiper_reg[i] <= preload_reg[i];
        else if (code == CMD_NV_COPY && !cmd_data_reg[D0_BIT] && !all_ch)
        begin
          wiper_reg[i] <= nvm_reg[i];
          preload_reg[i] <= nvm_reg[i];
        end
      end
    end

    // nonvolatile image, factory midscale at power-up
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
        nvm_reg[i] <= NVM_DEFAULT;
      else if (cmd_go_reg && sel[i] && !all_ch)
      begin
        if (code == CMD_NV_COPY && cmd_data_reg[D0_BIT])
          nvm_reg[i] <= wiper_reg[i];
        else if (code == CMD_NV_WRITE)
          nvm_reg[i] <= data_m;
      end
    end

    // shutdown flag leaves the wiper contents alone
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
        shutdown[i] <= 1'b0;
      else if (cmd_go_reg && sel[i] && code == CMD_SHUTDOWN)
        shutdown[i] <= cmd_data_reg[D0_BIT];
    end

    // taps straight from the wiper registers
    assign wiper_tap[i*BYTE_W +: BYTE_W] = wiper_reg[i];
    assign wiper_flat[i*BYTE_W +: BYTE_W] = wiper_reg[i];
    assign nvm_flat[i*BYTE_W +: BYTE_W] = nvm_reg[i];
  end

  // store lock and reload timers; reload runs once after reset
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      store_cnt_reg <= '0;
      rst_cnt_reg <= ONE; // power-up reload next cycle
    end
    else
    begin
      if (cmd_go_reg && sel != 4'h0 && !all_ch
          && ((code == CMD_NV_COPY && cmd_data_reg[D0_BIT])
              || code == CMD_NV_WRITE))
        store_cnt_reg <= STORE_LOAD;
      else if (store_cnt_reg != '0)
        store_cnt_reg <= store_cnt_reg - ONE;
      if (cmd_go_reg && code == CMD_SOFT_RESET)
        rst_cnt_reg <= RESET_LOAD;
      else if (rst_cnt_reg != '0)
        rst_cnt_reg <= rst_cnt_reg - ONE;
    end
  end

  // readback source and channel
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rb_ch_reg <= 2'h0;
      rb_src_reg <= RB_WIPER;
    end
    else if (cmd_go_reg && code == CMD_READBACK && sel != 4'h0 && !all_ch)
    begin
      rb_ch_reg <= cmd_hi_reg[1:0];
      rb_src_reg <= {cmd_data_reg[D1_BIT], cmd_data_reg[D0_BIT]};
    end
  end

  // byte shifted out to the master
  assign rb_byte = ((rb_src_reg == RB_NVM) ? nvm_reg[rb_ch_reg]
                   : wiper_reg[rb_ch_reg]) & LSB_MASK;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ahb_wr_reg <= 1'b0;
      ahb_addr_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ahb_wr_reg <= 1'b0;
      if (hsel && htrans[HTRANS_ACT_BIT] && hready)
      begin
        ahb_wr_reg <= hwrite;
        ahb_addr_reg <= haddr[7:0];
        // read data prepared for the data phase
        unique case (haddr[7:0])
          REG_CTRL: hrdata <= {31'h0, ctrl_en_reg};
          REG_STATUS: hrdata <= {24'h0, rb_src_reg, shutdown,
                                 rst_cnt_reg != '0, store_cnt_reg != '0};
          REG_WIPER: hrdata <= wiper_flat;
          REG_NVM: hrdata <= nvm_flat;
          default: hrdata <= 32'h0; // unmapped reads zero
        endcase
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_en_reg <= CTRL_RESET;
    else if (ahb_wr_reg && ahb_addr_reg == REG_CTRL)
      ctrl_en_reg <= hwdata[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_store_cmd;
    cmd_go_reg && code == CMD_NV_WRITE && !all_ch && !cmd_hi_reg[NONE_BIT];
  endsequence

  sequence s_addr_end;
    scl_fall && state_reg == ST_ADDR && bit_cnt_reg == BIT_ACK;
  endsequence

  chk_store_lock: assert property (@(posedge clock) disable iff (!rst_b)
    s_store_cmd |=> locked [*8])
    else $error("store did not lock the device");

  chk_locked_nack: assert property (@(posedge clock) disable iff (!rst_b)
    s_addr_end and locked |=> !sda_oe)
    else $error("acknowledge given while locked");

  chk_addr_ack: assert property (@(posedge clock) disable iff (!rst_b)
    s_addr_end and !locked and ctrl_en_reg
    and shift_reg[7:1] == own_addr_reg |=> sda_oe ##0 state_reg != ST_WAIT)
    else $error("matching address not acknowledged");

  chk_wiper_write: assert property (@(posedge clock) disable iff (!rst_b)
    cmd_go_reg && code == CMD_WR_WIPER && !all_ch && !cmd_hi_reg[NONE_BIT]
    && !load_now |=> wiper_reg[$past(cmd_hi_reg[1:0])] == $past(data_m)
    && preload_reg[$past(cmd_hi_reg[1:0])] == $past(data_m))
    else $error("wiper or preload not written");

  chk_preload_only: assert property (@(posedge clock) disable iff (!rst_b)
    cmd_go_reg && code == CMD_WR_PRE && !load_now |=> $stable(wiper_flat))
    else $error("preload write moved a wiper");

  chk_nop_still: assert property (@(posedge clock) disable iff (!rst_b)
    cmd_go_reg && code == CMD_NOP && !load_now
    |=> $stable(wiper_flat) && $stable(nvm_flat) && $stable(shutdown))
    else $error("no-operation changed state");

  chk_lsb_clear: assert property (@(posedge clock) disable iff (!rst_b)
    cmd_go_reg && code == CMD_WR_WIPER && POSITIONS == 256 && !load_now
    && all_ch |=> wiper_reg[0][0] == 1'b0 && wiper_reg[3][0] == 1'b0)
    else $error("data bit zero not ignored");

  chk_drive_low: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(sda_oe) |-> !scl_s)
    else $error("sda pulled while scl high");

  chk_shutdown_all: assert property (@(posedge clock) disable iff (!rst_b)
    cmd_go_reg && code == CMD_SHUTDOWN && all_ch
    |=> shutdown == {4{$past(cmd_data_reg[D0_BIT])}} && $stable(wiper_flat))
    else $error("shutdown not applied to all channels");

  chk_reset_reload: assert property (@(posedge clock) disable iff (!rst_b)
    load_now |=> wiper_flat == $past(nvm_flat))
    else $error("reload did not copy nonvolatile values");

endmodule // quad_pot_i2c_command_core

// ==== bench/i2c_master_model.sv ====
// Purpose: serial bus master model that drives the pot core's link
// Assumes: scl half period of eight core clocks, 64 ns link period
// Notes: sda_drv low pulls the line low, high releases it to pull-up
`timescale 1ns/1ns
module i2c_master_model
(
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // idle bus: clock stands high between frames, data released
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // wait a number of core clocks
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start();
    wt(4);
    sda_drv <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_drv <= 1'b0;
    wt(8);
    scl <= 1'b0;
  endtask
  // one pulse: data moves mid low phase, sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    wt(4);
    sda_drv <= b;
    wt(4);
    scl <= 1'b1;
    wt(8);
    r = sda_line;
    scl <= 1'b0;
  endtask
  // byte out, most significant bit first, ninth pulse gives the ack
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // byte in, then ack, or nack on the last byte
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    // released line on the last byte is the nack, low is the ack
    bit_io(last, r);
  endtask
  // stop: data low, then rises while clock is high
  task automatic stop();
    wt(4);
    sda_drv <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_drv <= 1'b1;
    wt(8);
  endtask
endmodule // i2c_master_model

// ==== bench/quad_pot_i2c_command_core_test.sv ====
// Purpose: self-checking bench for the quad pot command core
// Assumes: shortened lock counts, 256-position build
// Notes: expected notes are queued and compared against results seen
`timescale 1ns/1ns
module quad_pot_i2c_command_core_test;
  import pot_pkg::*;
  localparam int SC = 400; // store lock, spans a further byte
  localparam int RC = 20; // reload time
  localparam logic [6:0] SG = 7'h2B; // grounded strap address
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] addr_sel = 2'h0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic scl, sda_drv, sda_o, sda_oe, hreadyout, hresp;
  logic [31:0] hrdata, wiper_tap;
  logic [3:0] shutdown;
  wire sda_line = sda_drv & !(sda_oe & !sda_o);
  int errors = 0;
  int comparisons = 0;
  string nq[$]; // names of checks
  logic [31:0] eq[$], gq[$]; // expected and seen
  logic [31:0] seed = 32'h347F4E8D;
  logic [31:0] wip = 32'h80808080; // expected wipers
  logic [31:0] nvm = 32'h80808080; // expected stored values
  logic [6:0] sa_tab [3] = '{7'h2B, 7'h2A, 7'h28};
  logic [2:0] ak;
  logic [31:0] rd;
  logic [7:0] b;
  always #2 clock = ~clock;
  quad_pot_i2c_command_core #(.STORE_CNT(SC), .RESET_CNT(RC)) DUT
  (
    .clock, .rst_b, .scl_in(scl), .sda_in(sda_line), .addr_sel, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .sda_o, .sda_oe, .hrdata, .hreadyout, .hresp, .wiper_tap, .shutdown
  );
  i2c_master_model host
  (
    .clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
  );
  ////////////////////////////////////////////////////////////////////////
  // xorshift source for data values
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // queue an expectation and the value seen
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    nq.push_back(n);
    eq.push_back(e);
    gq.push_back(s);
  endtask
  // watcher: compares the oldest note with the oldest result
  always @(posedge clock)
  begin
    while (eq.size() > 0 && gq.size() > 0)
    begin
      comparisons++;
      if (gq[0] !== eq[0])
      begin
        errors++;
        $display("MISMATCH %s expected %h seen %h", nq[0], eq[0], gq[0]);
      end
      nq.delete(0);
      eq.delete(0);
      gq.delete(0);
    end
  end
  // single word transfer on the register bus
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    r = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  // one command word in one write frame; acks of the three bytes
  task automatic cmd(input logic [6:0] sa, input logic [3:0] c,
                     input logic [3:0] ch, input logic [7:0] d,
                     output logic [2:0] a);
    host.start();
    host.put({sa, 1'b0}, a[2]);
    host.put({c, ch}, a[1]);
    host.put(d, a[0]);
    host.stop();
  endtask
  // command to the grounded-strap device, all bytes acknowledged
  task automatic go(input logic [3:0] c, input logic [3:0] ch,
                    input logic [7:0] d);
    cmd(SG, c, ch, d, ak);
    chk("ack", 32'h7, ak);
  endtask
  // select a readback source, then read one byte
  task automatic rbk(input logic [3:0] ch, input logic [1:0] s,
                     output logic [7:0] v);
    logic a;
    go(CMD_READBACK, ch, {6'h0, s});
    host.start();
    host.put({SG, 1'b1}, a);
    chk("read ack", 32'h1, a);
    host.get(1'b1, v);
    host.stop();
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0 && eq.size() == 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial
  begin
    repeat (60000) @(posedge clock);
    errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (8) @(posedge clock);
    ahb(1'b0, REG_WIPER, 32'h0, rd);
    chk("wipers", wip, rd);
    chk("tap", wip, wiper_tap);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    // strap addresses, foreign addresses, disabled slave
    for (int i = 0; i < 3; i++)
    begin
      addr_sel <= 2'(i);
      cmd(sa_tab[i], CMD_NOP, 4'h0, 8'h00, ak);
      chk("strap", 32'h7, ak);
      cmd(sa_tab[(i + 1) % 3], CMD_NOP, 4'h0, 8'h00, ak);
      chk("foreign", 32'h0, ak);
    end
    addr_sel <= 2'h0;
    cmd(7'h00, CMD_NOP, 4'h0, 8'h00, ak);
    chk("general call", 32'h0, ak);
    cmd(7'h78, CMD_NOP, 4'h0, 8'h00, ak);
    chk("ten bit", 32'h0, ak);
    ahb(1'b1, REG_CTRL, 32'h0, rd);
    cmd(SG, CMD_NOP, 4'h0, 8'h00, ak);
    chk("disabled", 32'h0, ak);
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    $display("test address done");
    // wiper, preload and transfer
    rd = rnd();
    b = {1'b0, rd[6:0]} | 8'h01;
    go(CMD_WR_WIPER, 4'h0, b);
    wip[7:0] = b & 8'hFE;
    chk("tap write", wip, wiper_tap);
    go(CMD_WR_PRE, 4'h1, 8'h33);
    chk("tap preload", wip, wiper_tap);
    go(CMD_TRANSFER, 4'h1, 8'h00);
    wip[15:8] = 8'h32;
    chk("tap transfer", wip, wiper_tap);
    go(CMD_TRANSFER, 4'h0, 8'h00);
    chk("tap preload copy", wip, wiper_tap);
    rbk(4'h0, RB_WIPER, b);
    chk("read wiper", wip[7:0], b);
    rbk(4'h0, RB_NVM, b);
    chk("read stored", nvm[7:0], b);
    $display("test wiper done");
    // store with lock, then restore
    go(CMD_NV_COPY, 4'h0, 8'h01);
    nvm[7:0] = wip[7:0];
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk("lock busy", 32'h1, rd & 32'h1);
    cmd(SG, CMD_WR_WIPER, 4'h0, 8'h10, ak);
    chk("locked", 32'h0, ak);
    repeat (SC) @(posedge clock);
    go(CMD_WR_WIPER, 4'h0, 8'h10);
    go(CMD_NV_COPY, 4'h0, 8'h00);
    chk("tap restore", wip, wiper_tap);
    go(CMD_NV_WRITE, 4'h2, 8'h45);
    nvm[23:16] = 8'h44;
    repeat (SC) @(posedge clock);
    ahb(1'b0, REG_NVM, 32'h0, rd);
    chk("stored", nvm, rd);
    chk("tap kept", wip, wiper_tap);
    $display("test store done");
    // channel field, shutdown, no-operation, software reset
    go(CMD_WR_WIPER, 4'h4, 8'h00);
    chk("no channel", wip, wiper_tap);
    rd = rnd();
    go(CMD_WR_WIPER, 4'h8, rd[7:0]);
    wip = {4{rd[7:0] & 8'hFE}};
    chk("all channels", wip, wiper_tap);
    go(CMD_SHUTDOWN, 4'h8, 8'h01);
    chk("shutdown all", 32'hF, shutdown);
    go(CMD_SHUTDOWN, 4'h2, 8'h00);
    chk("shutdown one", 32'hB, shutdown);
    chk("tap shutdown", wip, wiper_tap);
    go(CMD_NOP, 4'h8, 8'hFF);
    chk("nop tap", wip, wiper_tap);
    chk("nop shutdown", 32'hB, shutdown);
    go(CMD_SOFT_RESET, 4'h0, 8'h00);
    repeat (RC + 8) @(posedge clock);
    wip = nvm;
    chk("reload", wip, wiper_tap);
    $display("test commands done");
    repeat (2) @(posedge clock);
    report_and_stop();
  end
endmodule // quad_pot_i2c_command_core_test
